// file: rtl/bdc_top.sv
// write/read qualifier drive and cache policy line-state decision
`timescale 1ns/10ps
`default_nettype none
`include "bdc_cfg.svh"
module bdc_top
    import bdc_pkg::*;
#(
    parameter int BURST_BEATS = `BDC_BURST_BEATS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // cycle request from the bus unit
    input wire logic cyc_start,
    input wire bdc_cyc_t cyc_type,
    input wire logic cyc_burst,
    input wire logic cyc_cacheable,
    input wire logic cyc_line_hit_shared,
    input wire logic cyc_line_hit_excl,
    input wire logic page_write_through_attr,
    // writeback demand from snoop, flush or instruction
    input wire logic inquire_hit_mod,
    input wire logic internal_snoop_mod,
    input wire logic flush_req,
    input wire logic writeback_invalidate_instr,
    // bus pins from system logic, already synchronous
    input wire logic burst_ready_in_n,
    input wire logic next_address_request_n,
    input wire logic bus_backoff_n,
    input wire logic bus_hold_req,
    input wire logic cache_policy_select,
    // bus pins to system logic
    output logic address_strobe_n,
    output logic write_read_o,
    output logic write_read_oe,
    output logic bus_surrender_ack,
    // cache-line update result
    output logic line_upd_valid,
    output bdc_line_t line_upd_state,
    output logic ext_write_req,
    output logic writeback_req,
    output logic cyc_done
);
    // four-bit beat counter; three ignored beats need four at least
    if (BURST_BEATS < 4 || BURST_BEATS > 8) begin : g_beats_check
        $error("BURST_BEATS must be 4..8");
    end

    logic rst_sync_n;
    bdc_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    bdc_state_t state_ff, nxt_state;
    bdc_cyc_t type_ff, nxt_type;
    logic [3:0] beat_ff, nxt_beat;
    logic burst_ff, nxt_burst;
    logic fill_ff, nxt_fill;
    logic wshr_ff, nxt_wshr;
    logic wexc_ff, nxt_wexc;
    logic pol_ff, nxt_pol;
    logic wt_attr_ff, nxt_wt_attr;
    logic pol_taken_ff, nxt_pol_taken;
    logic strobe_ff, nxt_strobe;
    logic wr_ff, nxt_wr;
    logic oe_ff, nxt_oe;
    logic surr_ff, nxt_surr;
    logic upd_v_ff, nxt_upd_v;
    bdc_line_t upd_s_ff, nxt_upd_s;
    logic extw_ff, nxt_extw;
    logic wb_ff, nxt_wb;
    logic done_ff, nxt_done;

    logic rdy, addr_adv, backoff, last_beat, policy_used, wb_demand;
    bdc_line_t fill_state;

    assign rdy = ~burst_ready_in_n;
    assign addr_adv = ~next_address_request_n;
    assign backoff = ~bus_backoff_n;
    assign last_beat = burst_ff ? (beat_ff == 4'(BURST_BEATS - 1)) : 1'b1;
    // policy matters only for memory reads and plain writes
    assign policy_used = (type_ff == BDC_CYC_MEM_RD) ||
                         (type_ff == BDC_CYC_MEM_WR); // [R12]
    assign wb_demand = inquire_hit_mod | internal_snoop_mod |
                       flush_req | writeback_invalidate_instr;
    // exclusive only with writeback policy and no writethrough attr
    assign fill_state = (pol_ff && !wt_attr_ff) ? BDC_LINE_EXC // [R7]
                                            : BDC_LINE_SHR; // [R5]

    // next-state for the bus cycle and pin drive
    always_comb begin
        nxt_state = state_ff;
        nxt_type = type_ff;
        nxt_beat = beat_ff;
        nxt_burst = burst_ff;
        nxt_fill = fill_ff;
        nxt_wshr = wshr_ff;
        nxt_wexc = wexc_ff;
        nxt_pol = pol_ff;
        nxt_wt_attr = wt_attr_ff;
        nxt_pol_taken = pol_taken_ff;
        nxt_strobe = 1'b1;
        nxt_wr = wr_ff;
        nxt_oe = oe_ff;
        nxt_surr = surr_ff;
        nxt_upd_v = 1'b0;
        nxt_upd_s = upd_s_ff;
        nxt_extw = 1'b0;
        nxt_wb = wb_demand; // [R9]
        nxt_done = 1'b0;
        case (state_ff)
            BDC_ST_IDLE: begin
                if (backoff) begin
                    nxt_oe = 1'b0; // [R3]
                end else if (bus_hold_req) begin
                    nxt_surr = 1'b1;
                    nxt_oe = 1'b0; // [R3]
                    nxt_state = BDC_ST_FLOAT;
                end else if (cyc_start) begin
                    nxt_state = BDC_ST_ACTIVE;
                    nxt_type = cyc_type;
                    nxt_beat = 4'h0;
                    nxt_burst = cyc_burst && (cyc_type == BDC_CYC_MEM_RD);
                    nxt_fill = cyc_cacheable && (cyc_type == BDC_CYC_MEM_RD);
                    nxt_wshr = cyc_line_hit_shared &&
                               (cyc_type == BDC_CYC_MEM_WR);
                    nxt_wexc = cyc_line_hit_excl &&
                               (cyc_type == BDC_CYC_MEM_WR);
                    nxt_wt_attr = page_write_through_attr; // [R13]
                    nxt_pol_taken = 1'b0;
                    nxt_strobe = 1'b0;
                    nxt_oe = 1'b1; // [R1] [R2]
                    // writes, io writes, special cycles drive high
                    nxt_wr = (cyc_type == BDC_CYC_MEM_WR ||
                              cyc_type == BDC_CYC_WRBACK ||
                              cyc_type == BDC_CYC_IO_WR ||
                              cyc_type == BDC_CYC_SPECIAL)
                             ? `BDC_DIR_WRITE : `BDC_DIR_READ; // [R4]
                end else if (cyc_line_hit_excl &&
                             cyc_type == BDC_CYC_MEM_WR) begin
                    // silent upgrade, nothing goes to the bus
                    nxt_upd_v = 1'b1;
                    nxt_upd_s = BDC_LINE_MOD; // [R8]
                end
            end
            BDC_ST_ACTIVE: begin
                if (backoff) begin
                    nxt_oe = 1'b0; // [R3]
                    nxt_state = BDC_ST_IDLE;
                end else if (rdy || addr_adv) begin
                    // first ready or next-address only; later beats ignored
                    if (!pol_taken_ff && policy_used) begin
                        nxt_pol = cache_policy_select; // [R10] [R11]
                        nxt_pol_taken = 1'b1;
                    end
                    if (rdy) begin
                        nxt_beat = beat_ff + 4'h1;
                    end
                    // qualifier held until next-address or final ready
                    if (addr_adv || (rdy && last_beat)) begin // [R1]
                        nxt_oe = 1'b0;
                    end
                    if (rdy && last_beat) begin
                        nxt_state = BDC_ST_IDLE;
                        nxt_done = 1'b1;
                        nxt_extw = wshr_ff; // [R6]
                        if (fill_ff || wshr_ff) begin
                            nxt_upd_v = 1'b1;
                            nxt_upd_s = (pol_taken_ff || !policy_used)
                                ? fill_state
                                : ((cache_policy_select && !wt_attr_ff)
                                   ? BDC_LINE_EXC : BDC_LINE_SHR); // [R13]
                        end else if (wexc_ff) begin
                            nxt_upd_v = 1'b1;
                            nxt_upd_s = BDC_LINE_MOD; // [R8]
                        end
                    end
                end
            end
            BDC_ST_FLOAT: begin
                nxt_oe = 1'b0;
                if (!bus_hold_req) begin
                    nxt_surr = 1'b0;
                    nxt_state = BDC_ST_IDLE;
                end
            end
            default: begin
                nxt_state = BDC_ST_IDLE;
            end
        endcase
    end

    // register stage; outputs come straight from these
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= BDC_ST_IDLE;
            type_ff <= BDC_CYC_MEM_RD;
            beat_ff <= 4'h0;
            burst_ff <= 1'b0;
            fill_ff <= 1'b0;
            wshr_ff <= 1'b0;
            wexc_ff <= 1'b0;
            pol_ff <= 1'b0;
            wt_attr_ff <= 1'b0;
            pol_taken_ff <= 1'b0;
            strobe_ff <= 1'b1;
            wr_ff <= 1'b0;
            oe_ff <= 1'b0;
            surr_ff <= 1'b0;
            upd_v_ff <= 1'b0;
            upd_s_ff <= BDC_LINE_INV;
            extw_ff <= 1'b0;
            wb_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            type_ff <= nxt_type;
            beat_ff <= nxt_beat;
            burst_ff <= nxt_burst;
            fill_ff <= nxt_fill;
            wshr_ff <= nxt_wshr;
            wexc_ff <= nxt_wexc;
            pol_ff <= nxt_pol;
            wt_attr_ff <= nxt_wt_attr;
            pol_taken_ff <= nxt_pol_taken;
            strobe_ff <= nxt_strobe;
            wr_ff <= nxt_wr;
            oe_ff <= nxt_oe;
            surr_ff <= nxt_surr;
            upd_v_ff <= nxt_upd_v;
            upd_s_ff <= nxt_upd_s;
            extw_ff <= nxt_extw;
            wb_ff <= nxt_wb;
            done_ff <= nxt_done;
        end
    end

    assign address_strobe_n = strobe_ff;
    assign write_read_o = wr_ff;
    assign write_read_oe = oe_ff;
    assign bus_surrender_ack = surr_ff;
    assign line_upd_valid = upd_v_ff;
    assign line_upd_state = upd_s_ff;
    assign ext_write_req = extw_ff;
    assign writeback_req = wb_ff;
    assign cyc_done = done_ff;
endmodule : bdc_top
`default_nettype wire

// file: rtl/bdc_cfg.svh
// constants for the bus direction and cache policy block
// Functional notes
// (R1) drive direction with strobe, hold until done; the block also releases it at next-address
// (R2) direction driven for mem, io, special, inta
// (R3) float direction on backoff or surrender ack
// (R4) direction encodes write versus read cycles
// (R5) policy low or writethrough attr: shared state
// (R6) writes to shared lines go to bus
// (R7) policy high and attr low: exclusive state
// (R8) write hit exclusive becomes modified, silent
// (R9) modified lines written back on demand
// (R10) sample policy at first ready or next-address
// (R11) ignore policy on last three burst readies
// (R12) policy used only mem read, non-writeback write
// (R13) latch policy with attr, apply at completion
`ifndef BDC_CFG_SVH
`define BDC_CFG_SVH
`define BDC_BURST_BEATS 4
`define BDC_DIR_WRITE 1'b1
`define BDC_DIR_READ 1'b0
`endif

// file: rtl/bdc_pkg.sv
// types for the bus direction and cache policy block
package bdc_pkg;
    typedef enum logic [2:0] {
        BDC_CYC_MEM_RD = 3'h0,
        BDC_CYC_MEM_WR = 3'h1,
        BDC_CYC_WRBACK = 3'h2,
        BDC_CYC_IO_RD = 3'h3,
        BDC_CYC_IO_WR = 3'h4,
        BDC_CYC_INTA = 3'h5,
        BDC_CYC_SPECIAL = 3'h6
    } bdc_cyc_t;
    typedef enum logic [1:0] {
        BDC_LINE_INV = 2'h0,
        BDC_LINE_SHR = 2'h1,
        BDC_LINE_EXC = 2'h3,
        BDC_LINE_MOD = 2'h2
    } bdc_line_t;
    typedef enum logic [1:0] {
        BDC_ST_IDLE = 2'h0,
        BDC_ST_ACTIVE = 2'h1,
        BDC_ST_FLOAT = 2'h3
    } bdc_state_t;
endpackage : bdc_pkg

// file: rtl/bdc_sync.sv
// two-stage synchroniser for the reset release
`timescale 1ns/10ps
`default_nettype none
module bdc_sync (
    // clock and raw asynchronous reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // synchronised reset
    output logic rst_sync_n
);
    logic meta_ff;
    logic hold_ff;

    // first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            meta_ff <= 1'b1;
            hold_ff <= meta_ff;
        end
    end
    assign rst_sync_n = hold_ff;
endmodule : bdc_sync
`default_nettype wire

// file: bench/bdc_checker.sv
// assertion checker for the bus direction and cache policy block
`timescale 1ns/10ps
`default_nettype none
module bdc_checker
    import bdc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // inputs of the block
    input wire logic cyc_start,
    input wire bdc_cyc_t cyc_type,
    input wire logic next_address_request_n,
    input wire logic bus_backoff_n,
    // outputs of the block
    input wire logic address_strobe_n,
    input wire logic write_read_o,
    input wire logic write_read_oe,
    input wire logic bus_surrender_ack,
    input wire logic cyc_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // write-type cycles drive the qualifier high
    function automatic logic dir_of(bdc_cyc_t t);
        return t inside {BDC_CYC_MEM_WR, BDC_CYC_WRBACK, BDC_CYC_IO_WR,
            BDC_CYC_SPECIAL};
    endfunction : dir_of
    sequence s_launch;
        $fell(address_strobe_n);
    endsequence
    property p_dir;
        s_launch |-> write_read_oe && write_read_o == dir_of($past(cyc_type));
    endproperty
    AST_STROBE_CAUSE: assert property (s_launch |-> $past(cyc_start))
        else $error("strobe without a cycle start");
    AST_DIR_AT_STROBE: assert property (p_dir)
        else $error("qualifier wrong at strobe");
    AST_STROBE_PULSE: assert property (
        !address_strobe_n |=> address_strobe_n)
        else $error("strobe longer than one cycle");
    AST_DIR_STANDS: assert property (
        write_read_oe && $past(write_read_oe) |-> $stable(write_read_o))
        else $error("qualifier moved mid cycle");
    AST_NA_RELEASE: assert property (
        !next_address_request_n && write_read_oe && address_strobe_n
        |=> !write_read_oe)
        else $error("qualifier held past next-address");
    AST_BACKOFF_FLOAT: assert property (
        !bus_backoff_n |=> !write_read_oe)
        else $error("driven after backoff");
    AST_HOLD_FLOAT: assert property (
        $rose(bus_surrender_ack) |-> !write_read_oe)
        else $error("driven at surrender ack");
    AST_DONE_PULSE: assert property (
        cyc_done |-> !write_read_oe ##1 !cyc_done)
        else $error("done pulse wrong");
endmodule : bdc_checker
bind bdc_top bdc_checker bdc_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .cyc_start(cyc_start), .cyc_type(cyc_type), .bus_backoff_n(bus_backoff_n),
    .next_address_request_n(next_address_request_n), .cyc_done(cyc_done),
    .address_strobe_n(address_strobe_n), .write_read_o(write_read_o),
    .write_read_oe(write_read_oe), .bus_surrender_ack(bus_surrender_ack));
`default_nettype wire

// file: bench/bdc_sys_model.sv
// system-side bus model answering the block's cycles
`timescale 1ns/10ps
`default_nettype none
`include "bdc_cfg.svh"
module bdc_sys_model #(
    parameter int BEATS = `BDC_BURST_BEATS
) (
    // clock and strobe from the block
    input wire logic clk_sys,
    input wire logic address_strobe_n,
    // wait states, burst, policy, next-address use
    input wire logic [3:0] wait_cyc,
    input wire logic burst,
    input wire logic pol,
    input wire logic use_adv,
    // answers to the block
    output logic burst_ready_in_n,
    output logic next_address_request_n,
    output logic cache_policy_select
);
    logic go;
    // policy toggles each idle cycle, holds through wait states and is inverted on the beats after the first
    initial begin
        burst_ready_in_n = 1'b1;
        next_address_request_n = 1'b1;
        cache_policy_select = 1'b0;
        forever begin
            @(posedge clk_sys);
            go = (address_strobe_n === 1'b0);
            #1;
            cache_policy_select = ~cache_policy_select;
            if (go) begin
                repeat (wait_cyc) begin
                    @(posedge clk_sys);
                    #1;
                end
                for (int i = 0; i < (burst ? BEATS : 1); i++) begin
                    burst_ready_in_n = 1'b0;
                    next_address_request_n = !(use_adv && i == 0);
                    cache_policy_select = (i == 0) ? pol : !pol;
                    @(posedge clk_sys);
                    #1;
                end
                burst_ready_in_n = 1'b1;
                next_address_request_n = 1'b1;
            end
        end
    end
endmodule : bdc_sys_model
`default_nettype wire

// file: bench/bdc_top_test.sv
// self-checking bench for the bus direction and cache policy block
`timescale 1ns/10ps
`default_nettype none
`include "bdc_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t value differs", $time); end end
module bdc_top_test;
    import bdc_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, cyc_start = 1'b0, bst = 1'b0;
    logic ca = 1'b0, hit_s = 1'b0, hit_x = 1'b0, wt_attr = 1'b0, hold = 1'b0;
    logic bkoff_n = 1'b1, m_pol = 1'b0, m_adv = 1'b0, rdy_n, adv_n, pol_in;
    logic strobe_n, wr_o, wr_oe, ack, upd_v, wb_req, ext_w, done, wr;
    logic [3:0] dmd = 4'h0, m_wait = 4'h0;
    bdc_cyc_t cyc_type = BDC_CYC_MEM_RD;
    bdc_line_t upd_s;
    bdc_line_t exp_q[$];
    int failures = 0, n_compared = 0, ext_n = 0, seed = 50, k, e0;
    always #4 clk_sys = ~clk_sys;
    bdc_top bdc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_start(cyc_start),
        .cyc_type(cyc_type), .cyc_burst(bst), .cyc_cacheable(ca),
        .cyc_line_hit_shared(hit_s), .cyc_line_hit_excl(hit_x),
        .page_write_through_attr(wt_attr), .inquire_hit_mod(dmd[3]),
        .internal_snoop_mod(dmd[2]), .flush_req(dmd[1]),
        .writeback_invalidate_instr(dmd[0]), .burst_ready_in_n(rdy_n),
        .next_address_request_n(adv_n), .bus_backoff_n(bkoff_n),
        .bus_hold_req(hold), .cache_policy_select(pol_in),
        .address_strobe_n(strobe_n), .write_read_o(wr_o), .write_read_oe(wr_oe),
        .bus_surrender_ack(ack), .line_upd_valid(upd_v),
        .line_upd_state(upd_s), .ext_write_req(ext_w), .writeback_req(wb_req),
        .cyc_done(done));
    bdc_sys_model bdc_sys_model_i (.clk_sys(clk_sys),
        .address_strobe_n(strobe_n), .wait_cyc(m_wait), .burst(bst),
        .pol(m_pol), .use_adv(m_adv), .burst_ready_in_n(rdy_n),
        .next_address_request_n(adv_n), .cache_policy_select(pol_in));
    // results are matched against the oldest note
    always @(posedge clk_sys) begin
        ext_n <= ext_n + int'(ext_w === 1'b1);
        // an update with no note pending is a mismatch too
        if (upd_v === 1'b1 && exp_q.size() > 0)
            `CHK(upd_s, exp_q.pop_front())
        else if (upd_v === 1'b1)
            `CHK(upd_v, 1'b0)
    end
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic limit(input int n);
        if (n >= 40) begin
            failures++;
            tally_and_finish();
        end
    endtask : limit
    // one bus cycle; cut ends it early with a backoff
    task automatic run(input bdc_cyc_t t, input logic cut);
        e0 = ext_n;
        cyc_type = t;
        bst = (t == BDC_CYC_MEM_RD) && 1'($random(seed));
        ca = !cut && (t == BDC_CYC_MEM_RD) && 1'($random(seed));
        hit_s = (t == BDC_CYC_MEM_WR) && 1'($random(seed));
        wt_attr = 1'($random(seed));
        m_pol = 1'($random(seed));
        m_wait = cut ? 4'hF : {2'h0, 2'($random(seed))};
        m_adv = !bst && 1'($random(seed));
        dmd = 4'($random(seed));
        wr = (t inside {BDC_CYC_MEM_WR, BDC_CYC_WRBACK, BDC_CYC_IO_WR,
            BDC_CYC_SPECIAL}) ? `BDC_DIR_WRITE : `BDC_DIR_READ;
        if (ca || hit_s)
            exp_q.push_back(bdc_line_t'((m_pol && !wt_attr) ?
                BDC_LINE_EXC : BDC_LINE_SHR));
        cyc_start = 1'b1;
        tick();
        cyc_start = 1'b0;
        wt_attr = ~wt_attr; // late change must not reach the update
        `CHK(wb_req, |dmd)
        for (k = 0; k < 40 && strobe_n !== 1'b0; k++) tick();
        limit(k);
        `CHK(wr_o, wr)
        if (cut) begin
            bkoff_n = 1'b0;
            tick();
            bkoff_n = 1'b1;
            `CHK(wr_oe, 1'b0)
            return;
        end
        for (k = 0; k < 40 && done !== 1'b1; k++) begin
            if (wr_oe === 1'b1) `CHK(wr_o, wr)
            tick();
        end
        limit(k);
        `CHK(wr_oe, 1'b0)
        tick();
        tick();
        if (hit_s) `CHK(ext_n > e0, 1'b1)
    endtask : run
    task automatic tally_and_finish();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // main sequence: all cycle kinds, silent hit, hold, backoff, reset
    initial begin
        repeat (6) tick();
        rst_n = 1'b1;
        repeat (3) tick();
        for (int i = 0; i < 35; i++) run(bdc_cyc_t'(i % 7), 1'b0);
        k = ext_n;
        exp_q.push_back(BDC_LINE_MOD);
        // the silent upgrade only follows a plain memory write hit
        cyc_type = BDC_CYC_MEM_WR;
        hit_x = 1'b1;
        tick();
        hit_x = 1'b0;
        repeat (4) tick();
        `CHK(exp_q.size() == 0 && ext_n == k, 1'b1)
        hold = 1'b1;
        for (k = 0; k < 40 && ack !== 1'b1; k++) tick();
        limit(k);
        `CHK(wr_oe, 1'b0)
        cyc_start = 1'b1;
        tick();
        cyc_start = 1'b0;
        tick();
        `CHK(strobe_n, 1'b1)
        hold = 1'b0;
        repeat (3) tick();
        run(BDC_CYC_MEM_RD, 1'b1);
        dmd = 4'h0;
        rst_n = 1'b0;
        repeat (20) tick();
        rst_n = 1'b1;
        repeat (3) tick();
        run(BDC_CYC_MEM_WR, 1'b0);
        `CHK(exp_q.size() == 0, 1'b1)
        tally_and_finish();
    end
endmodule : bdc_top_test
`default_nettype wire
